// ===== dv/lwrt_supervisory_timer_unit_tb.sv
// self-checking bench for the supervisory timer unit
`timescale 1ns/100ps
module lwrt_supervisory_timer_unit_tb;
  import lwrt_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              lfo_pin = 1'b0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  logic              sys_reset_req;
  logic              rst_pin_out;
  logic              rst_pin_oe_n;
  logic [31:0]       rd_v;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #10 sys_clk = ~sys_clk;

  lwrt_supervisory_timer_unit dut_u (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .lfo_pin         (lfo_pin),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .sys_reset_req   (sys_reset_req),
    .rst_pin_out     (rst_pin_out),
    .rst_pin_oe_n    (rst_pin_oe_n)
  );

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // sampled on the falling edge: settled, and stands until the next rise
  task automatic acc(bit w, logic [4:0] a, logic [31:0] d);
    logic wt;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(negedge sys_clk);
      wt   = avs_waitrequest;
      rd_v = avs_readdata;
      @(posedge sys_clk);
    end while (wt !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdc(string nm, logic [4:0] a, logic [31:0] m,
                     logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, rd_v & m, exp);
  endtask

  // slow edges so the input synchroniser sees every one
  task automatic lfo(int n);
    repeat (n) begin
      repeat (6) @(posedge sys_clk);
      lfo_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      lfo_pin <= 1'b0;
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h00000071);
    rdc("status", OFS_STATUS, 32'h00000071, 32'h00000070);
    rdc("unmapped", 5'h18, 32'hFFFFFFFF, 32'h00000000);
    chk("oe_n", rst_pin_oe_n, 32'h1);
    $display("test reset done");
    lfo(5);
    rdc("count", OFS_STATUS, 32'h3FFF0000, 32'h00050000);
    repeat (50) @(posedge sys_clk);
    rdc("count idle", OFS_STATUS, 32'h3FFF0000, 32'h00050000);
    acc(1'b1, OFS_RESTART, 32'h00000001);
    rdc("count rst", OFS_STATUS, 32'h3FFF0000, 32'h00000000);
    $display("test restart done");
    acc(1'b1, OFS_CTRL, 32'h00000001);
    rdc("sel old", OFS_STATUS, 32'h00000070, 32'h00000070);
    acc(1'b1, OFS_RESTART, 32'h00000001);
    rdc("sel new", OFS_STATUS, 32'h00000070, 32'h00000000);
    acc(1'b1, OFS_EVT_EN, 32'h00000003);
    lfo(33);
    rdc("evt half", OFS_EVT, 32'h00000003, 32'h00000002);
    chk("irq set", irq, 32'h1);
    acc(1'b1, OFS_EVT_CLR, 32'h00000003);
    @(negedge sys_clk);
    chk("irq clr", irq, 32'h0);
    $display("test interval done");
    acc(1'b1, OFS_CTRL, 32'h00000000);
    lfo(40);
    rdc("count off", OFS_STATUS, 32'h3FFF0001, 32'h00210000);
    acc(1'b1, OFS_CTRL, 32'h00000002);
    rdc("ctrl lock", OFS_CTRL, 32'h00000073, 32'h00000003);
    acc(1'b1, OFS_CTRL, 32'h00000070);
    rdc("ctrl kept", OFS_CTRL, 32'h00000073, 32'h00000003);
    rdc("evt blk", OFS_EVT, 32'h00000003, 32'h00000001);
    chk("irq blk", irq, 32'h1);
    acc(1'b1, OFS_EVT_EN, 32'h00000000);
    @(negedge sys_clk);
    chk("irq mask", irq, 32'h0);
    $display("test lock done");
    acc(1'b1, OFS_RESTART, 32'h00000001);
    lfo(63);
    chk("req early", sys_reset_req, 32'h0);
    lfo(1);
    chk("req ovf", sys_reset_req, 32'h1);
    chk("oe_n ovf", rst_pin_oe_n, 32'h1);
    chk("pin out", rst_pin_out, 32'h0);
    $display("test overflow done");
    do_reset();
    chk("req gone", sys_reset_req, 32'h0);
    rdc("ctrl unlk", OFS_CTRL, 32'h00000073, 32'h00000071);
    acc(1'b1, OFS_CTRL, 32'h00000000);
    rdc("ctrl dis", OFS_CTRL, 32'h00000073, 32'h00000000);
    $display("test relock done");
    end_sim;
  end
endmodule

// ===== logic/lwrt_pkg.sv
// constants shared by the supervisory timer unit
package lwrt_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_RESTART = 5'h04;
  localparam logic [4:0] OFS_STATUS  = 5'h08;
  localparam logic [4:0] OFS_EVT     = 5'h0C;
  localparam logic [4:0] OFS_EVT_CLR = 5'h10;
  localparam logic [4:0] OFS_EVT_EN  = 5'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_LOCK_BIT  = 1;
  localparam int CTRL_SEL_LSB   = 4;
  localparam int SEL_W          = 3;
  localparam int RESTART_BIT    = 0;
  localparam int ST_CNT_LSB     = 16;
  localparam int EVT_W          = 2;
  localparam int EVT_BLOCKED    = 0;
  localparam int EVT_HALFWAY    = 1;

  // ****************************************
  // counter sizing and reset values
  // ****************************************
  localparam int         BASE_EXP    = 6;
  localparam int         CNT_W       = 14;
  localparam logic [2:0] SEL_RST     = 3'h7;
  localparam logic       EN_RST      = 1'b1;
  localparam logic       LOCK_RST    = 1'b0;
  localparam logic [1:0] EVT_EN_RST  = 2'h0;

endpackage

// ===== logic/lwrt_supervisory_timer_unit.sv
// supervisory timer unit: lfo-driven counter that requests a system reset
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps

// Behaviour
// - count advances only on low-frequency oscillator edges, not system clock
// - counter overflow raises the system reset request
// - after any reset: enabled, counting, longest interval selected
// - software may disable the counter while it is not locked
// - a lock control holds the counter permanently enabled
// - lock ignores disables, stays set until reset clears it
// - while locked, control register writes including interval are rejected; event enable writes are still taken
// - overflow reset leaves the external reset pin undriven
module lwrt_supervisory_timer_unit
  import lwrt_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        lfo_pin,
  input  wire logic [lwrt_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [lwrt_pkg::DATA_W-1:0] avs_writedata,
  output logic      [lwrt_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             irq,
  output logic                             sys_reset_req,
  output logic                             rst_pin_out,
  output logic                             rst_pin_oe_n
);

  // ****************************************
  // state
  // ****************************************
  logic             lfo_s1_r, lfo_s2_r, lfo_s3_r, lfo_lvl_r;
  logic             lfo_tick;
  logic             ack_r;
  logic [31:0]      rdata_r;
  logic             wr_take;
  logic             enabled_r, locked_r;
  logic [SEL_W-1:0] sel_r, active_sel_r;
  logic [CNT_W-1:0] cnt_r, lim;
  logic             reset_req_r;
  logic             restart_hit, ctrl_wr, ovf_hit, half_hit;
  logic [EVT_W-1:0] evt_r, evt_en_r, evt_set, evt_clr;

  // ****************************************
  // lfo edge detection
  // ****************************************
  // three stages; an edge counts only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lfo_s1_r  <= 1'b0;
      lfo_s2_r  <= 1'b0;
      lfo_s3_r  <= 1'b0;
      lfo_lvl_r <= 1'b0;
    end else begin
      lfo_s1_r <= lfo_pin;
      lfo_s2_r <= lfo_s1_r;
      lfo_s3_r <= lfo_s2_r;
      if (lfo_s2_r == lfo_s3_r) begin
        lfo_lvl_r <= lfo_s3_r;
      end
    end
  end

  assign lfo_tick = (lfo_s2_r == lfo_s3_r) && lfo_s3_r && !lfo_lvl_r;

  // a new tick needs the level to fall and rise back through both stages
  tick_gap_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lfo_tick |=> !lfo_tick [*3])
    else $error("lfo ticks closer than four cycles");

  // ****************************************
  // avalon slave
  // ****************************************
  // one wait cycle for every access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_take         = avs_write && ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (avs_read && !ack_r) begin
      unique case (avs_address)
        OFS_CTRL:   rdata_r <= {25'h0, sel_r, 2'h0, locked_r, enabled_r};
        OFS_STATUS: rdata_r <= {2'h0, cnt_r, 9'h0, active_sel_r,
                                3'h0, reset_req_r};
        OFS_EVT:    rdata_r <= {30'h0, evt_r};
        OFS_EVT_EN: rdata_r <= {30'h0, evt_en_r};
        default:    rdata_r <= 32'h0;
      endcase
    end
  end

  one_wait_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");

  wait_first_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new access answered without wait");

  rdata_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(avs_read && !ack_r) |=> $stable(avs_readdata))
    else $error("read data moved between reads");

  // ****************************************
  // control register
  // ****************************************
  assign ctrl_wr     = wr_take && (avs_address == OFS_CTRL);
  assign restart_hit = wr_take && (avs_address == OFS_RESTART)
                       && avs_writedata[RESTART_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enabled_r <= EN_RST;
      locked_r  <= LOCK_RST;
      sel_r     <= SEL_RST;
    end else if (ctrl_wr && !locked_r) begin
      sel_r <= avs_writedata[CTRL_SEL_LSB +: SEL_W];
      if (avs_writedata[CTRL_LOCK_BIT]) begin
        locked_r  <= 1'b1;
        enabled_r <= 1'b1;
      end else begin
        enabled_r <= avs_writedata[CTRL_EN_BIT];
      end
    end
  end

  reset_vals_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> enabled_r && !locked_r && sel_r == SEL_RST)
    else $error("bad state after reset");

  lock_sticky_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    locked_r |=> locked_r)
    else $error("lock dropped without reset");

  lock_enabled_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    locked_r |-> enabled_r)
    else $error("locked but disabled");

  lock_set_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && !locked_r && avs_writedata[CTRL_LOCK_BIT])
    |=> locked_r && enabled_r)
    else $error("lock write not applied");

  cfg_frozen_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    locked_r |=> $stable(sel_r))
    else $error("config changed when locked");

  disable_ok_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && !locked_r && !avs_writedata[CTRL_EN_BIT]
     && !avs_writedata[CTRL_LOCK_BIT]) |=> !enabled_r)
    else $error("disable write not applied");

  // ****************************************
  // counter and overflow
  // ****************************************
  assign lim = CNT_W'((32'h1 << (BASE_EXP + int'(active_sel_r))) - 32'h1);
  assign ovf_hit  = enabled_r && lfo_tick && !restart_hit
                    && (cnt_r == lim) && !reset_req_r;
  assign half_hit = enabled_r && lfo_tick && !restart_hit
                    && (cnt_r == (lim >> 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r        <= '0;
      active_sel_r <= SEL_RST;
    end else if (restart_hit) begin
      cnt_r        <= '0;
      active_sel_r <= sel_r;
    end else if (enabled_r && lfo_tick && !reset_req_r) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  restart_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    restart_hit |=> (cnt_r == '0) && (active_sel_r == $past(sel_r)))
    else $error("restart did not clear count");

  sel_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !restart_hit |=> $stable(active_sel_r))
    else $error("interval changed without restart");

  tick_only_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!lfo_tick && !restart_hit) |=> $stable(cnt_r))
    else $error("count moved without lfo edge");

  count_step_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (enabled_r && lfo_tick && !restart_hit && !reset_req_r)
    |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("lfo edge not counted once");

  off_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!enabled_r && !restart_hit) |=> $stable(cnt_r))
    else $error("count moved while disabled");

  count_freeze_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reset_req_r && !restart_hit) |=> $stable(cnt_r))
    else $error("count moved after overflow");

  // request holds until the system reset comes back round
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reset_req_r <= 1'b0;
    end else if (ovf_hit) begin
      reset_req_r <= 1'b1;
    end
  end

  assign sys_reset_req = reset_req_r;
  // pin never driven by this block
  assign rst_pin_out   = 1'b0;
  assign rst_pin_oe_n  = 1'b1;

  ovf_reset_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ovf_hit |=> sys_reset_req ##1 sys_reset_req)
    else $error("overflow without reset request");

  reset_cause_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(sys_reset_req) |-> $past(cnt_r) == $past(lim))
    else $error("reset request without overflow");

  req_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped early");

  pin_free_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sys_reset_req |-> rst_pin_oe_n)
    else $error("reset pin driven");

  pin_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_pin_oe_n && !rst_pin_out)
    else $error("reset pin output not released");

  // ****************************************
  // events and interrupt
  // ****************************************
  assign evt_set = {half_hit, ctrl_wr && locked_r};
  assign evt_clr = (wr_take && avs_address == OFS_EVT_CLR)
                   ? avs_writedata[EVT_W-1:0] : '0;

  // set beats clear so no event is lost in the clear cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      evt_r <= '0;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      evt_en_r <= EVT_EN_RST;
    end else if (wr_take && avs_address == OFS_EVT_EN) begin
      evt_en_r <= avs_writedata[EVT_W-1:0];
    end
  end

  assign irq = |(evt_r & evt_en_r);

  lock_reject_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && locked_r) |=> evt_r[EVT_BLOCKED])
    else $error("blocked write not flagged");

  evt_sticky_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (evt_r[EVT_BLOCKED] && !evt_clr[EVT_BLOCKED]) |=> evt_r[EVT_BLOCKED])
    else $error("event bit lost without clear");

  half_evt_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    half_hit |=> evt_r[EVT_HALFWAY])
    else $error("half interval not flagged");

  irq_mask_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (evt_en_r == '0) |-> !irq)
    else $error("interrupt raised while masked");

endmodule
